// file: design/cma_pkg.sv
// Package: register map, field masks and reset values for calendar/alarm
package cma_pkg;

  // ---------------------------------------------------------------
  // Register offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] CMA_OFS_MONTH = 8'h0d;
  localparam logic [7:0] CMA_OFS_YEAR = 8'h0e;
  localparam logic [7:0] CMA_OFS_AL_SEC = 8'h10;
  localparam logic [7:0] CMA_OFS_AL_MIN = 8'h11;
  localparam logic [7:0] CMA_OFS_AL_HOUR = 8'h12;
  localparam logic [7:0] CMA_OFS_AL_DAY = 8'h13;
  localparam logic [7:0] CMA_OFS_AL_WDAY = 8'h14;
  localparam logic [7:0] CMA_OFS_AL_MON = 8'h15;
  localparam logic [7:0] CMA_OFS_AL_YEAR = 8'h16;

  // ---------------------------------------------------------------
  // Alarm field indices and layout
  // ---------------------------------------------------------------
  localparam int CMA_NFIELDS = 7;
  localparam int CMA_F_SEC = 0;
  localparam int CMA_F_MIN = 1;
  localparam int CMA_F_HOUR = 2;
  localparam int CMA_F_DAY = 3;
  localparam int CMA_F_WDAY = 4;
  localparam int CMA_F_MON = 5;
  localparam int CMA_F_YEAR = 6;
  localparam int CMA_EN_BIT = 7;
  localparam int CMA_HOUR_MODE_BIT = 6;

  // Value masks per field (BCD bits only), then the alarm enable bit mask
  localparam logic [7:0] CMA_MASK_SEC = 8'h7f;
  localparam logic [7:0] CMA_MASK_MIN = 8'h7f;
  localparam logic [7:0] CMA_MASK_HOUR = 8'h3f;
  localparam logic [7:0] CMA_MASK_DAY = 8'h3f;
  localparam logic [7:0] CMA_MASK_WDAY = 8'h07;
  localparam logic [7:0] CMA_MASK_MON = 8'h1f;
  localparam logic [7:0] CMA_MASK_YEAR = 8'h7f;
  localparam logic [7:0] CMA_MASK_EN = 8'h80;

  // ---------------------------------------------------------------
  // Reset values and calendar constants
  // ---------------------------------------------------------------
  localparam logic [7:0] CMA_RST_MONTH = 8'h01;
  localparam logic [7:0] CMA_RST_YEAR = 8'h00;
  localparam logic [7:0] CMA_RST_ALARM = 8'h00;
  localparam logic [7:0] CMA_RST_DAYS = 8'h31;
  localparam logic [7:0] CMA_MONTH_FEB = 8'h02;
  localparam logic [7:0] CMA_MONTH_DEC = 8'h12;
  localparam logic [7:0] CMA_MONTH_JAN = 8'h01;
  localparam logic [7:0] CMA_YEAR_LAST = 8'h79;
  localparam logic [7:0] CMA_YEAR_FIRST = 8'h00;
  localparam logic [7:0] CMA_DAYS_28 = 8'h28;
  localparam logic [7:0] CMA_DAYS_29 = 8'h29;
  localparam logic [7:0] CMA_DAYS_30 = 8'h30;
  localparam logic [7:0] CMA_DAYS_31 = 8'h31;

endpackage

// file: design/cma_field_match.sv
// Module: per-field alarm comparators and the combined match
`timescale 1ns/1ps
module cma_field_match #(
  parameter int NFIELDS = cma_pkg::CMA_NFIELDS
) (
  input wire logic [NFIELDS-1:0][7:0] target_in,
  input wire logic [NFIELDS-1:0][7:0] current_in,
  input wire logic [NFIELDS-1:0][7:0] mask_in,
  output logic all_match_out,
  output logic any_enabled_out
);

  logic [NFIELDS-1:0] field_ok;
  logic [NFIELDS-1:0] field_en;

  genvar g;
  generate
    for (g = 0; g < NFIELDS; g++) begin : g_field
      assign field_en[g] = target_in[g][cma_pkg::CMA_EN_BIT];
      // Disabled field never blocks the combined match
      assign field_ok[g] = !field_en[g] ||
        ((target_in[g] & mask_in[g]) == (current_in[g] & mask_in[g]));
    end
  endgenerate

  // No enabled field means no alarm, rather than a match every cycle
  assign any_enabled_out = |field_en;
  assign all_match_out = any_enabled_out && (&field_ok);

endmodule // cma_field_match

// file: design/cma_calendar_alarm.sv
// Module: month/year calendar registers and alarm compare unit
`timescale 1ns/1ps
module cma_calendar_alarm (
  input wire logic sys_clk_in,
  input wire logic rst_in,
  // Host register port
  input wire logic [7:0] reg_addr_in,
  input wire logic reg_wr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic reg_rd_in,
  output logic [7:0] reg_rdata_out,
  output logic reg_rvalid_out,
  // Running time from the watch counters
  input wire logic [7:0] cur_second_in,
  input wire logic [7:0] cur_minute_in,
  input wire logic [7:0] cur_hour_in,
  input wire logic [7:0] cur_day_in,
  input wire logic [7:0] cur_weekday_in,
  input wire logic month_tick_in,
  // Alarm control
  input wire logic alarm_irq_enable_in,
  input wire logic alarm_flag_clear_in,
  output logic alarm_flag_out,
  output logic int_out,
  // Calendar state
  output logic [7:0] month_out,
  output logic [7:0] year_out,
  output logic [7:0] days_in_month_out,
  output logic leap_year_out
);

  localparam int NF = cma_pkg::CMA_NFIELDS;

  // ---------------------------------------------------------------
  // Field masks
  // ---------------------------------------------------------------
  logic [NF-1:0][7:0] val_mask;
  assign val_mask[cma_pkg::CMA_F_SEC] = cma_pkg::CMA_MASK_SEC;
  assign val_mask[cma_pkg::CMA_F_MIN] = cma_pkg::CMA_MASK_MIN;
  // Same six bits serve both formats: afternoon+hour or 24h BCD
  assign val_mask[cma_pkg::CMA_F_HOUR] = cma_pkg::CMA_MASK_HOUR;
  assign val_mask[cma_pkg::CMA_F_DAY] = cma_pkg::CMA_MASK_DAY;
  assign val_mask[cma_pkg::CMA_F_WDAY] = cma_pkg::CMA_MASK_WDAY;
  assign val_mask[cma_pkg::CMA_F_MON] = cma_pkg::CMA_MASK_MON;
  assign val_mask[cma_pkg::CMA_F_YEAR] = cma_pkg::CMA_MASK_YEAR;

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  function automatic logic [7:0] bcd_inc(input logic [7:0] v);
    logic [7:0] r;
    r = v;
    if (v[3:0] == 4'h9) begin
      r = {v[7:4] + 4'h1, 4'h0};
    end else begin
      r = {v[7:4], v[3:0] + 4'h1};
    end
    return r;
  endfunction

  // BCD year divisible by four: even tens with 0/4/8, odd tens with 2/6
  function automatic logic is_leap(input logic [7:0] y);
    logic r;
    r = 1'b0;
    if (!y[4]) begin
      r = (y[3:0] == 4'h0) || (y[3:0] == 4'h4) || (y[3:0] == 4'h8);
    end else begin
      r = (y[3:0] == 4'h2) || (y[3:0] == 4'h6);
    end
    return r;
  endfunction

  function automatic logic [7:0] month_days(input logic [7:0] m,
                                            input logic lp);
    logic [7:0] d;
    d = cma_pkg::CMA_DAYS_31;
    case (m)
      cma_pkg::CMA_MONTH_FEB: d = lp ? cma_pkg::CMA_DAYS_29
                                     : cma_pkg::CMA_DAYS_28;
      8'h04, 8'h06, 8'h09, 8'h11: d = cma_pkg::CMA_DAYS_30;
      default: d = cma_pkg::CMA_DAYS_31;
    endcase
    return d;
  endfunction

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  logic [7:0] month_r, month_nxt;
  logic [7:0] year_r, year_nxt;
  logic [NF-1:0][7:0] alarm_r, alarm_nxt;
  logic [7:0] days_r, days_nxt;
  logic leap_r, leap_nxt;
  logic match_prev_r, match_prev_nxt;
  logic flag_r, flag_nxt;
  logic [7:0] rdata_r, rdata_nxt;
  logic rvalid_r, rvalid_nxt;

  logic [NF-1:0][7:0] current;
  logic all_match;
  logic any_enabled;
  logic match_rise;

  assign current[cma_pkg::CMA_F_SEC] = cur_second_in;
  assign current[cma_pkg::CMA_F_MIN] = cur_minute_in;
  // Mode bit is outside the compare mask; it only names the format
  assign current[cma_pkg::CMA_F_HOUR] = cur_hour_in;
  assign current[cma_pkg::CMA_F_DAY] = cur_day_in;
  assign current[cma_pkg::CMA_F_WDAY] = cur_weekday_in;
  assign current[cma_pkg::CMA_F_MON] = month_r;
  assign current[cma_pkg::CMA_F_YEAR] = year_r;

  cma_field_match #(
    .NFIELDS(NF)
  ) u_match (
    .target_in(alarm_r),
    .current_in(current),
    .mask_in(val_mask),
    .all_match_out(all_match),
    .any_enabled_out(any_enabled)
  );

  // ---------------------------------------------------------------
  // Calendar and register writes
  // ---------------------------------------------------------------
  always_comb begin
    month_nxt = month_r;
    year_nxt = year_r;
    alarm_nxt = alarm_r;
    if (month_tick_in) begin
      if (month_r == cma_pkg::CMA_MONTH_DEC) begin
        month_nxt = cma_pkg::CMA_MONTH_JAN;
        if (year_r == cma_pkg::CMA_YEAR_LAST) begin
          year_nxt = cma_pkg::CMA_YEAR_FIRST;
        end else begin
          year_nxt = bcd_inc(year_r) & cma_pkg::CMA_MASK_YEAR;
        end
      end else begin
        month_nxt = bcd_inc(month_r) & cma_pkg::CMA_MASK_MON;
      end
    end
    // A host write wins over the calendar advance in the same cycle
    if (reg_wr_in) begin
      for (int i = 0; i < NF; i++) begin
        if (reg_addr_in == cma_pkg::CMA_OFS_AL_SEC + 8'(i)) begin
          alarm_nxt[i] = reg_wdata_in & (val_mask[i] |
                                         cma_pkg::CMA_MASK_EN);
        end
      end
      if (reg_addr_in == cma_pkg::CMA_OFS_MONTH) begin
        month_nxt = reg_wdata_in & cma_pkg::CMA_MASK_MON;
      end
      if (reg_addr_in == cma_pkg::CMA_OFS_YEAR) begin
        year_nxt = reg_wdata_in & cma_pkg::CMA_MASK_YEAR;
      end
    end
    leap_nxt = is_leap(year_nxt);
    days_nxt = month_days(month_nxt, leap_nxt);
  end

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      month_r <= cma_pkg::CMA_RST_MONTH;
      year_r <= cma_pkg::CMA_RST_YEAR;
      alarm_r <= {NF{cma_pkg::CMA_RST_ALARM}};
      leap_r <= 1'b1;
      days_r <= cma_pkg::CMA_RST_DAYS;
    end else begin
      month_r <= month_nxt;
      year_r <= year_nxt;
      alarm_r <= alarm_nxt;
      leap_r <= leap_nxt;
      days_r <= days_nxt;
    end
  end

  // ---------------------------------------------------------------
  // Alarm flag
  // ---------------------------------------------------------------
  assign match_rise = all_match && !match_prev_r;

  always_comb begin
    match_prev_nxt = all_match;
    flag_nxt = flag_r;
    if (alarm_flag_clear_in) begin
      flag_nxt = 1'b0;
    end
    // Set beats clear so a coincident match is never lost
    if (match_rise && alarm_irq_enable_in) begin
      flag_nxt = 1'b1;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      match_prev_r <= 1'b0;
      flag_r <= 1'b0;
    end else begin
      match_prev_r <= match_prev_nxt;
      flag_r <= flag_nxt;
    end
  end

  // ---------------------------------------------------------------
  // Register read
  // ---------------------------------------------------------------
  always_comb begin
    rdata_nxt = 8'h00;
    rvalid_nxt = reg_rd_in;
    if (reg_rd_in) begin
      for (int i = 0; i < NF; i++) begin
        if (reg_addr_in == cma_pkg::CMA_OFS_AL_SEC + 8'(i)) begin
          rdata_nxt = alarm_r[i];
        end
      end
      if (reg_addr_in == cma_pkg::CMA_OFS_MONTH) begin
        rdata_nxt = month_r;
      end
      if (reg_addr_in == cma_pkg::CMA_OFS_YEAR) begin
        rdata_nxt = year_r;
      end
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      rdata_r <= 8'h00;
      rvalid_r <= 1'b0;
    end else begin
      rdata_r <= rdata_nxt;
      rvalid_r <= rvalid_nxt;
    end
  end

  assign reg_rdata_out = rdata_r;
  assign reg_rvalid_out = rvalid_r;
  assign alarm_flag_out = flag_r;
  assign int_out = flag_r && alarm_irq_enable_in;
  assign month_out = month_r;
  assign year_out = year_r;
  assign days_in_month_out = days_r;
  assign leap_year_out = leap_r;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (rst_in);

  month_resv_a: assert property (
    month_r[7:5] == 3'h0)
    else $error("month reserved bits not zero");

  leap_feb_a: assert property (
    (month_r == cma_pkg::CMA_MONTH_FEB && year_r == 8'h00)
      |-> days_r == cma_pkg::CMA_DAYS_29)
    else $error("year zero February lacks day 29");

  non_leap_a: assert property (
    (month_r == cma_pkg::CMA_MONTH_FEB && year_r == 8'h13)
      |-> days_r == cma_pkg::CMA_DAYS_28)
    else $error("non leap February has 29 days");

  year_wrap_a: assert property (
    (month_tick_in && !reg_wr_in && month_r == cma_pkg::CMA_MONTH_DEC
      && year_r == cma_pkg::CMA_YEAR_LAST)
      |=> (year_r == 8'h00 && month_r == 8'h01))
    else $error("year did not wrap after 79");

  flag_set_a: assert property (
    (all_match && !match_prev_r && alarm_irq_enable_in)
      |=> flag_r && int_out == alarm_irq_enable_in)
    else $error("alarm flag not set on match");

  disabled_ignored_a: assert property (
    !any_enabled |-> ##1 !$rose(flag_r))
    else $error("alarm fired with no field enabled");

  wday_mask_a: assert property (
    alarm_r[cma_pkg::CMA_F_WDAY][6:3] == 4'h0)
    else $error("weekday alarm reserved bits set");

  unmapped_read_a: assert property (
    (reg_rd_in && reg_addr_in == 8'h0f) |=> rvalid_r && rdata_r == 8'h00)
    else $error("unmapped read not zero");

  no_retrigger_a: assert property (
    (!flag_r && all_match && match_prev_r) |=> !flag_r)
    else $error("flag set during continuing match");

  flag_sticky_a: assert property (
    (flag_r && !alarm_flag_clear_in) |=> flag_r)
    else $error("alarm flag dropped without clear");

  alarm_fire_c: cover property (match_rise && alarm_irq_enable_in);
  year_wrap_c: cover property (
    month_tick_in && month_r == cma_pkg::CMA_MONTH_DEC
      && year_r == cma_pkg::CMA_YEAR_LAST);
  leap_feb_c: cover property (days_r == cma_pkg::CMA_DAYS_29);
  set_clear_c: cover property (match_rise && alarm_flag_clear_in);

endmodule // cma_calendar_alarm

// file: verification/cma_calendar_alarm_tb.sv
// Testbench: register map, calendar roll-over and alarm match checks
`timescale 1ns/1ps
module cma_calendar_alarm_tb;
  logic sys_clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic [7:0] addr = 8'h00;
  logic wr = 1'b0;
  logic [7:0] wdata = 8'h00;
  logic rd = 1'b0;
  logic [7:0] rdata;
  logic rvalid;
  logic [7:0] c_sec = 8'h00;
  logic [7:0] c_min = 8'h00;
  logic [7:0] c_hour = 8'h00;
  logic [7:0] c_day = 8'h01;
  logic [7:0] c_wday = 8'h01;
  logic tick = 1'b0;
  logic irq_en = 1'b0;
  logic clr = 1'b0;
  logic flag;
  logic irq;
  logic [7:0] month;
  logic [7:0] year;
  logic [7:0] days;
  logic leap;
  int n_errors = 0;
  int n_tests = 0;
  int cycles = 0;

  always #12.5 sys_clk_in = ~sys_clk_in;

  cma_calendar_alarm u_cma_calendar_alarm (
    .sys_clk_in(sys_clk_in),
    .rst_in(rst_in),
    .reg_addr_in(addr),
    .reg_wr_in(wr),
    .reg_wdata_in(wdata),
    .reg_rd_in(rd),
    .reg_rdata_out(rdata),
    .reg_rvalid_out(rvalid),
    .cur_second_in(c_sec),
    .cur_minute_in(c_min),
    .cur_hour_in(c_hour),
    .cur_day_in(c_day),
    .cur_weekday_in(c_wday),
    .month_tick_in(tick),
    .alarm_irq_enable_in(irq_en),
    .alarm_flag_clear_in(clr),
    .alarm_flag_out(flag),
    .int_out(irq),
    .month_out(month),
    .year_out(year),
    .days_in_month_out(days),
    .leap_year_out(leap)
  );

  // ---------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------
  task automatic print_verdict;
    $display("Counts: %0d compares, %0d mismatches", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge sys_clk_in);
  endtask

  // Strobe dropped a full cycle before the next request, never re-raised
  // in the same time step
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    addr = a;
    wdata = d;
    wr = 1'b1;
    cyc(1);
    wr = 1'b0;
    cyc(1);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    addr = a;
    rd = 1'b1;
    cyc(1);
    rd = 1'b0;
    check({7'h00, rvalid}, 8'h01);
    check(rdata, exp);
    cyc(1);
  endtask

  task automatic pulse_tick;
    tick = 1'b1;
    cyc(1);
    tick = 1'b0;
    cyc(1);
  endtask

  task automatic clr_flag;
    clr = 1'b1;
    cyc(1);
    clr = 1'b0;
    cyc(2);
  endtask

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic test_reset;
    rd_chk(cma_pkg::CMA_OFS_MONTH, 8'h01);
    rd_chk(cma_pkg::CMA_OFS_YEAR, 8'h00);
    for (int i = 0; i < 7; i++) begin
      rd_chk(8'h10 + 8'(i), 8'h00);
    end
    check(days, 8'h31);
    check({7'h00, leap}, 8'h01);
    $display("test_reset done");
  endtask

  task automatic test_masks;
    logic [7:0] ofs [9];
    logic [7:0] msk [9];
    ofs = '{8'h0d, 8'h0e, 8'h10, 8'h11, 8'h12, 8'h13, 8'h14, 8'h15, 8'h16};
    msk = '{8'h1f, 8'h7f, 8'hff, 8'hff, 8'hbf, 8'hbf, 8'h87, 8'h9f, 8'hff};
    for (int i = 0; i < 9; i++) begin
      wr_reg(ofs[i], 8'hff);
      rd_chk(ofs[i], msk[i]);
    end
    wr_reg(8'h0f, 8'h5a);
    rd_chk(8'h0f, 8'h00);
    for (int i = 2; i < 9; i++) begin
      wr_reg(ofs[i], 8'h00);
    end
    $display("test_masks done");
  endtask

  task automatic test_calendar;
    wr_reg(cma_pkg::CMA_OFS_MONTH, 8'h12);
    wr_reg(cma_pkg::CMA_OFS_YEAR, 8'h79);
    pulse_tick();
    check(month, 8'h01);
    check(year, 8'h00);
    check({7'h00, leap}, 8'h01);
    wr_reg(cma_pkg::CMA_OFS_MONTH, 8'h09);
    pulse_tick();
    check(month, 8'h10);
    wr_reg(cma_pkg::CMA_OFS_MONTH, 8'h02);
    wr_reg(cma_pkg::CMA_OFS_YEAR, 8'h13);
    check(days, 8'h28);
    wr_reg(cma_pkg::CMA_OFS_YEAR, 8'h04);
    check(days, 8'h29);
    // BCD 10 is binary sixteen: a binary test would wrongly call it leap
    wr_reg(cma_pkg::CMA_OFS_YEAR, 8'h10);
    check(days, 8'h28);
    wr_reg(cma_pkg::CMA_OFS_YEAR, 8'h12);
    check(days, 8'h29);
    $display("test_calendar done");
  endtask

  task automatic test_alarm;
    irq_en = 1'b1;
    wr_reg(8'h11, 8'h05);
    wr_reg(8'h10, 8'hb0);
    c_min = 8'h10;
    c_sec = 8'h30;
    cyc(2);
    check({7'h00, flag}, 8'h01);
    check({7'h00, irq}, 8'h01);
    clr_flag();
    check({7'h00, flag}, 8'h00);
    c_sec = 8'h31;
    cyc(1);
    irq_en = 1'b0;
    c_sec = 8'h30;
    cyc(2);
    check({7'h00, flag}, 8'h00);
    irq_en = 1'b1;
    cyc(2);
    check({7'h00, flag}, 8'h00);
    c_sec = 8'h00;
    wr_reg(8'h10, 8'h00);
    wr_reg(8'h11, 8'h95);
    wr_reg(8'h13, 8'hb1);
    wr_reg(8'h14, 8'h87);
    c_day = 8'h31;
    c_wday = 8'h07;
    cyc(2);
    check({7'h00, flag}, 8'h00);
    c_min = 8'h15;
    cyc(2);
    check({7'h00, flag}, 8'h01);
    clr_flag();
    wr_reg(8'h11, 8'h00);
    wr_reg(8'h13, 8'h00);
    wr_reg(8'h14, 8'h00);
    wr_reg(8'h12, 8'ha1);
    c_hour = 8'h41;
    cyc(2);
    check({7'h00, flag}, 8'h00);
    c_hour = 8'h61;
    cyc(2);
    check({7'h00, flag}, 8'h01);
    clr_flag();
    wr_reg(8'h12, 8'ha3);
    c_hour = 8'h23;
    cyc(2);
    check({7'h00, flag}, 8'h01);
    clr_flag();
    wr_reg(8'h12, 8'h00);
    wr_reg(cma_pkg::CMA_OFS_MONTH, 8'h05);
    wr_reg(8'h15, 8'h85);
    check({7'h00, flag}, 8'h01);
    clr_flag();
    wr_reg(8'h15, 8'h00);
    wr_reg(cma_pkg::CMA_OFS_YEAR, 8'h42);
    wr_reg(8'h16, 8'hc2);
    check({7'h00, flag}, 8'h01);
    irq_en = 1'b0;
    cyc(1);
    check({7'h00, irq}, 8'h00);
    // Clear held across a fresh match must not swallow the new alarm
    wr_reg(8'h16, 8'h00);
    irq_en = 1'b1;
    clr = 1'b1;
    wr_reg(8'h16, 8'hc2);
    clr = 1'b0;
    check({7'h00, flag}, 8'h01);
    $display("test_alarm done");
  endtask

  // ---------------------------------------------------------------
  // Run control
  // ---------------------------------------------------------------
  // Whole run needs well under a thousand cycles
  always @(posedge sys_clk_in) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      n_errors++;
      print_verdict();
    end
  end

  initial begin
    repeat (2) @(posedge sys_clk_in);
    @(negedge sys_clk_in);
    rst_in = 1'b0;
    test_reset();
    test_masks();
    test_calendar();
    test_alarm();
    print_verdict();
  end
endmodule // cma_calendar_alarm_tb
